// >>> rtl/sto_mc_odt.sv
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module sto_mc_odt #(
  parameter int CK_HALF = 2
) (
  // system
  input  wire logic        clk,
  input  wire logic        srst,
  // axi4-lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // link
  sto_link_if.ctrl         link
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (CK_HALF < 1) begin : g_chk
    $error("sto_mc_odt: CK_HALF must be at least 1");
  end
  localparam int DW = $clog2(CK_HALF + 1);

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  sto_pkg::sto_ctrl_t ctrl_ff;
  logic               wacc_ff;
  logic               bvalid_ff;
  logic [1:0]         bresp_ff;
  logic               arready_ff;
  logic               rvalid_ff;
  logic [31:0]        rdata_ff;
  logic [1:0]         rresp_ff;
  logic [31:0]        stat_w;
  logic [31:0]        ctrl_wr;

  wire logic w_fire  = wacc_ff & awvalid & wvalid;
  wire logic w_ctrl  = w_fire & (awaddr == sto_pkg::REG_CTRL);
  wire logic w_cmd   = w_fire & (awaddr == sto_pkg::REG_CMD) & wstrb[0];
  wire logic w_map   = (awaddr == sto_pkg::REG_CTRL) | (awaddr == sto_pkg::REG_CMD);
  wire logic r_fire  = arready_ff & arvalid;
  wire logic r_map   = (araddr == sto_pkg::REG_CTRL) | (araddr == sto_pkg::REG_CMD) |
                       (araddr == sto_pkg::REG_STAT);
  wire logic [31:0] r_word = (araddr == sto_pkg::REG_CTRL) ? ctrl_ff :
                             (araddr == sto_pkg::REG_STAT) ? stat_w : 32'h0000_0000;

  always_comb begin
    ctrl_wr = ctrl_ff;
    for (int i = 0; i < 4; i++) begin
      if (wstrb[i]) begin
        ctrl_wr[8*i +: 8] = wdata[8*i +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_ff    <= sto_pkg::CTRL_RST;
      wacc_ff    <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= sto_pkg::RESP_OK;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= sto_pkg::RESP_OK;
    end else begin
      // address and data are taken together, one pulse per write
      wacc_ff    <= awvalid & wvalid & ~wacc_ff & ~bvalid_ff;
      arready_ff <= arvalid & ~arready_ff & ~rvalid_ff;
      if (w_ctrl) begin
        ctrl_ff      <= ctrl_wr;
        ctrl_ff.rsvd <= '0;
      end
      if (w_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= w_map ? sto_pkg::RESP_OK : sto_pkg::RESP_ERR;
      end else if (bready) begin
        bvalid_ff <= 1'b0;
      end
      if (r_fire) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= r_word;
        rresp_ff  <= r_map ? sto_pkg::RESP_OK : sto_pkg::RESP_ERR;
      end else if (rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // link clock divider, odt, cke and command outputs change on the falling ck
  // ----------------------------------------------------------------
  logic [DW-1:0] div_ff;
  logic          ck_ff;

  wire logic div_wrap = div_ff == DW'(CK_HALF - 1);
  wire logic fall     = div_wrap & ck_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      div_ff <= '0;
      ck_ff  <= 1'b0;
    end else begin
      div_ff <= div_wrap ? '0 : div_ff + DW'(1);
      ck_ff  <= ck_ff ^ div_wrap;
    end
  end

  // ----------------------------------------------------------------
  // command scheduling, one decision per ck cycle
  // ----------------------------------------------------------------
  logic       odt_ff, cke_ff, wr_ff, bc4_ff, rd_ff;
  logic       wr_pend_ff, wr_bc4_ff, rd_pend_ff;
  logic [2:0] hold_ff;
  logic [4:0] rdblk_ff;
  logic [4:0] lowcnt_ff;

  wire logic signed [5:0] cl_s   = $signed({2'b00, ctrl_ff.cl});
  wire logic signed [5:0] cwl_s  = $signed({2'b00, ctrl_ff.cwl});
  wire logic signed [5:0] lead_s = cwl_s - cl_s + sto_pkg::RD_LEAD;
  wire logic signed [5:0] tail_s = cl_s - cwl_s + sto_pkg::RD_TAIL - 6'sh01;
  wire logic [4:0] tail    = (tail_s < 6'sh01) ? 5'h01 : tail_s[4:0];
  wire logic       lead_ok = lead_s <= $signed({1'b0, lowcnt_ff});
  wire logic       wr_dyn  = ctrl_ff.rtt_wr != 2'h0;
  wire logic       blk_clr = rdblk_ff == 5'h00;

  wire logic issue_wr = wr_pend_ff & blk_clr;
  // requested odt is masked only by the read guard, even with nominal termination off
  wire logic nxt_odt  = (hold_ff != 3'h0) | (issue_wr & wr_dyn) |
                        (ctrl_ff.odt_req & blk_clr & ~rd_pend_ff);
  wire logic issue_rd = rd_pend_ff & ~issue_wr & ~nxt_odt & lead_ok;

  wire logic [2:0] hold_base = (hold_ff != 3'h0) ? hold_ff - 3'h1 : 3'h0;
  wire logic [2:0] hold_a    = (nxt_odt & ~odt_ff) ? sto_pkg::HOLD4 : hold_base;
  wire logic [2:0] hold_w    = ~(issue_wr & nxt_odt) ? 3'h0 :
                               wr_bc4_ff ? sto_pkg::HOLD4 : sto_pkg::HOLD8;
  wire logic [2:0] nxt_hold  = (hold_a > hold_w) ? hold_a : hold_w;

  // a command write is refused while one of its kind is pending, unless that one issues in the same cycle
  wire logic set_wr = w_cmd & wdata[sto_pkg::CMD_WR] & (~wr_pend_ff | (fall & issue_wr));
  wire logic set_rd = w_cmd & wdata[sto_pkg::CMD_RD] & (~rd_pend_ff | (fall & issue_rd));

  always_ff @(posedge clk) begin
    if (srst) begin
      {odt_ff, cke_ff, wr_ff, bc4_ff, rd_ff} <= 5'h00;
      {wr_pend_ff, wr_bc4_ff, rd_pend_ff}    <= 3'h0;
      hold_ff   <= 3'h0;
      rdblk_ff  <= 5'h00;
      lowcnt_ff <= 5'h00;
    end else begin
      if (fall) begin
        odt_ff    <= nxt_odt;
        cke_ff    <= ctrl_ff.cke;
        wr_ff     <= issue_wr;
        bc4_ff    <= issue_wr & wr_bc4_ff;
        rd_ff     <= issue_rd;
        hold_ff   <= nxt_hold;
        rdblk_ff  <= issue_rd ? tail : blk_clr ? 5'h00 : rdblk_ff - 5'h01;
        lowcnt_ff <= nxt_odt ? 5'h00 : (&lowcnt_ff) ? lowcnt_ff : lowcnt_ff + 5'h01;
      end
      // set wins over the issue that clears
      wr_pend_ff <= set_wr | (wr_pend_ff & ~(fall & issue_wr));
      rd_pend_ff <= set_rd | (rd_pend_ff & ~(fall & issue_rd));
      if (set_wr) begin
        wr_bc4_ff <= wdata[sto_pkg::CMD_BC4];
      end
    end
  end

  assign stat_w = {27'h0, ~blk_clr, hold_ff != 3'h0, rd_pend_ff, wr_pend_ff, odt_ff};

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign awready         = wacc_ff;
  assign wready          = wacc_ff;
  assign bvalid          = bvalid_ff;
  assign bresp           = bresp_ff;
  assign arready         = arready_ff;
  assign rvalid          = rvalid_ff;
  assign rdata           = rdata_ff;
  assign rresp           = rresp_ff;
  assign link.ck         = ck_ff;
  assign link.cke        = cke_ff;
  assign link.odt        = odt_ff;
  assign link.wr_cmd     = wr_ff;
  assign link.wr_bc4     = bc4_ff;
  assign link.rd_cmd     = rd_ff;
  assign link.mr_al      = ctrl_ff.al;
  assign link.mr_cwl     = ctrl_ff.cwl;
  assign link.mr_cl      = ctrl_ff.cl;
  assign link.mr_rtt_nom = ctrl_ff.rtt_nom;
  assign link.mr_rtt_wr  = ctrl_ff.rtt_wr;
  assign link.mr_dll_pd  = ctrl_ff.dll_pd;

endmodule

// >>> include/sto_pkg.sv
package sto_pkg;

  // ----------------------------------------------------------------
  // latency and hold figures, in link clock cycles
  // ----------------------------------------------------------------
  localparam logic [4:0] LAT_OFS = 5'h02;
  localparam logic [2:0] ODTH4   = 3'h4;
  localparam logic [2:0] ODTH8   = 3'h6;
  localparam logic [2:0] HOLD4   = ODTH4 - 3'h1;
  localparam logic [2:0] HOLD8   = ODTH8 - 3'h1;
  // read guard: odt low lead before and tail after a read, beyond CL-CWL
  localparam logic signed [5:0] RD_LEAD = 6'sh01;
  localparam logic signed [5:0] RD_TAIL = 6'sh07;

  // ----------------------------------------------------------------
  // mode field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] AL_CL1      = 2'h1;
  localparam logic [1:0] AL_CL2      = 2'h2;
  localparam logic [2:0] NOM_RSV_MIN = 3'h6;
  localparam logic [1:0] WR_RSV      = 2'h3;

  // ----------------------------------------------------------------
  // controller registers
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL = 8'h00;
  localparam logic [7:0]  REG_CMD  = 8'h04;
  localparam logic [7:0]  REG_STAT = 8'h08;
  localparam int          CMD_WR   = 0;
  localparam int          CMD_RD   = 1;
  localparam int          CMD_BC4  = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0652;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  typedef struct packed {
    logic [13:0] rsvd;
    logic        dll_pd;
    logic [1:0]  rtt_wr;
    logic [2:0]  rtt_nom;
    logic [3:0]  cl;
    logic [3:0]  cwl;
    logic [1:0]  al;
    logic        cke;
    logic        odt_req;
  } sto_ctrl_t;

  typedef struct packed {
    logic       dll_locked;
    logic       banks_open;
    logic       dll_pd;
    logic [1:0] rtt_wr;
    logic [2:0] rtt_nom;
    logic [3:0] cl;
    logic [3:0] cwl;
    logic [1:0] al;
  } sto_mode_t;

  typedef enum logic [1:0] {STO_RTT_OFF, STO_RTT_NOM, STO_RTT_WR} sto_rtt_t;

  // additive latency in cycles from its mode code
  function automatic logic [4:0] al_cycles(input logic [1:0] code, input logic [3:0] cl);
    logic [4:0] v;
    v = 5'h00;
    if (code == AL_CL1) begin
      v = {1'b0, cl} - 5'h01;
    end else if (code == AL_CL2) begin
      v = {1'b0, cl} - 5'h02;
    end
    return v;
  endfunction

endpackage

// >>> include/sto_link_if.sv
`timescale 1ns/10ps
interface sto_link_if;
  logic       ck;
  logic       cke;
  logic       odt;
  logic       wr_cmd;
  logic       wr_bc4;
  logic       rd_cmd;
  logic [1:0] mr_al;
  logic [3:0] mr_cwl;
  logic [3:0] mr_cl;
  logic [2:0] mr_rtt_nom;
  logic [1:0] mr_rtt_wr;
  logic       mr_dll_pd;

  modport ctrl (output ck, cke, odt, wr_cmd, wr_bc4, rd_cmd, mr_al, mr_cwl, mr_cl,
                output mr_rtt_nom, mr_rtt_wr, mr_dll_pd);
  modport dram (input ck, cke, odt, wr_cmd, wr_bc4, rd_cmd, mr_al, mr_cwl, mr_cl,
                input mr_rtt_nom, mr_rtt_wr, mr_dll_pd);
endinterface

// >>> rtl/sto_dram_odt.sv
`timescale 1ns/10ps
module sto_dram_odt #(
  parameter int HIST_W = 32
) (
  // link
  sto_link_if.dram          link,
  // device side, ck domain reset and status levels
  input  wire logic         srst,
  input  wire logic         dll_locked,
  input  wire logic         banks_open,
  // termination state
  output sto_pkg::sto_rtt_t rtt_state,
  output logic [2:0]        nom_code,
  output logic [1:0]        wr_code,
  output logic              sync_mode,
  output logic              odt_int,
  // misuse flags
  output logic              cfg_err,
  output logic              hold_err
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (HIST_W < 32) begin : g_chk
    $error("sto_dram_odt: HIST_W must be at least 32");
  end

  // ----------------------------------------------------------------
  // mode and status synchroniser
  // ----------------------------------------------------------------
  sto_pkg::sto_mode_t mode_meta_ff;
  sto_pkg::sto_mode_t mode_ff;
  wire sto_pkg::sto_mode_t mode_raw = {dll_locked, banks_open, link.mr_dll_pd, link.mr_rtt_wr,
                                       link.mr_rtt_nom, link.mr_cl, link.mr_cwl, link.mr_al};

  always_ff @(posedge link.ck) begin
    mode_meta_ff <= mode_raw;
    mode_ff      <= mode_meta_ff;
  end

  // ----------------------------------------------------------------
  // latency decode
  // ----------------------------------------------------------------
  wire logic [4:0] al_val  = sto_pkg::al_cycles(mode_ff.al, mode_ff.cl);
  wire logic [4:0] wl      = {1'b0, mode_ff.cwl} + al_val;
  wire logic       lat_ok  = wl > sto_pkg::LAT_OFS;
  // history index for a sample taken ODTLon/ODTLoff cycles ago
  wire logic [4:0] lat_idx = lat_ok ? wl - sto_pkg::LAT_OFS - 5'h01 : 5'h00;
  wire logic [4:0] al_idx  = al_val - 5'h01;

  // ----------------------------------------------------------------
  // termination mode decode
  // ----------------------------------------------------------------
  // reserved resistor codes are treated as disabled and flagged
  wire logic nom_rsv  = mode_ff.rtt_nom >= sto_pkg::NOM_RSV_MIN;
  wire logic wr_rsv   = mode_ff.rtt_wr == sto_pkg::WR_RSV;
  wire logic nom_en   = (mode_ff.rtt_nom != 3'h0) & ~nom_rsv;
  wire logic dyn_en   = (mode_ff.rtt_wr != 2'h0) & ~wr_rsv;
  wire logic term_en  = nom_en | dyn_en;
  // cke high: active, refresh or idle; cke low: power-down flavours
  wire logic pd_ok    = link.cke | mode_ff.banks_open | mode_ff.dll_pd;
  wire logic sync_ok  = mode_ff.dll_locked & term_en & pd_ok;

  // ----------------------------------------------------------------
  // pin history, sampled at each rising ck
  // ----------------------------------------------------------------
  logic [HIST_W-1:0] odt_hist_ff;
  logic [HIST_W-1:0] wr_hist_ff;
  logic [HIST_W-1:0] bc4_hist_ff;

  always_ff @(posedge link.ck) begin
    if (srst) begin
      odt_hist_ff <= '0;
      wr_hist_ff  <= '0;
      bc4_hist_ff <= '0;
    end else begin
      odt_hist_ff <= {odt_hist_ff[HIST_W-2:0], link.odt};
      wr_hist_ff  <= {wr_hist_ff[HIST_W-2:0], link.wr_cmd};
      bc4_hist_ff <= {bc4_hist_ff[HIST_W-2:0], link.wr_cmd & link.wr_bc4};
    end
  end

  wire logic on_now  = odt_hist_ff[lat_idx];
  wire logic wr_now  = wr_hist_ff[lat_idx];
  wire logic bc4_now = bc4_hist_ff[lat_idx];
  // internal odt: pin delayed by the additive latency alone
  wire logic nxt_odt_int = (al_val == 5'h00) ? link.odt : odt_hist_ff[al_idx];

  // ----------------------------------------------------------------
  // write termination window
  // ----------------------------------------------------------------
  logic [2:0] wr_cnt_ff;

  wire logic [2:0] wr_len     = bc4_now ? sto_pkg::ODTH4 : sto_pkg::ODTH8;
  wire logic       wr_load    = wr_now & dyn_en;
  wire logic [2:0] wr_dec     = (wr_cnt_ff != 3'h0) ? wr_cnt_ff - 3'h1 : 3'h0;
  wire logic [2:0] nxt_wr_cnt = wr_load ? wr_len : wr_dec;

  always_ff @(posedge link.ck) begin
    if (srst) begin
      wr_cnt_ff <= 3'h0;
    end else begin
      wr_cnt_ff <= nxt_wr_cnt;
    end
  end

  // ----------------------------------------------------------------
  // termination state
  // ----------------------------------------------------------------
  wire logic in_wr = (nxt_wr_cnt != 3'h0) & dyn_en;
  wire sto_pkg::sto_rtt_t nxt_rtt = !(sync_ok & on_now) ? sto_pkg::STO_RTT_OFF :
                                    in_wr ? sto_pkg::STO_RTT_WR :
                                    nom_en ? sto_pkg::STO_RTT_NOM :
                                    sto_pkg::STO_RTT_OFF;

  sto_pkg::sto_rtt_t rtt_ff;
  logic              sync_ff;
  logic              odt_int_ff;
  logic [2:0]        nom_code_ff;
  logic [1:0]        wr_code_ff;
  logic              cfg_err_ff;

  always_ff @(posedge link.ck) begin
    if (srst) begin
      rtt_ff      <= sto_pkg::STO_RTT_OFF;
      sync_ff     <= 1'b0;
      odt_int_ff  <= 1'b0;
      nom_code_ff <= 3'h0;
      wr_code_ff  <= 2'h0;
      cfg_err_ff  <= 1'b0;
    end else begin
      rtt_ff      <= nxt_rtt;
      sync_ff     <= sync_ok;
      odt_int_ff  <= nxt_odt_int;
      nom_code_ff <= nom_rsv ? 3'h0 : mode_ff.rtt_nom;
      wr_code_ff  <= wr_rsv ? 2'h0 : mode_ff.rtt_wr;
      cfg_err_ff  <= nom_rsv | wr_rsv;
    end
  end

  // ----------------------------------------------------------------
  // hold watch on the controller
  // ----------------------------------------------------------------
  // hold_ff counts edges, this one included, at which odt must be high
  logic       odt_prev_ff;
  logic [2:0] hold_ff;
  logic       hold_err_ff;

  wire logic       odt_rise  = link.odt & ~odt_prev_ff;
  wire logic [2:0] hold_base = (hold_ff != 3'h0) ? hold_ff - 3'h1 : 3'h0;
  wire logic [2:0] hold_a    = odt_rise ? sto_pkg::HOLD4 : hold_base;
  wire logic [2:0] hold_w    = ~(link.wr_cmd & link.odt) ? 3'h0 :
                               link.wr_bc4 ? sto_pkg::HOLD4 : sto_pkg::HOLD8;
  wire logic       hold_miss = ~link.odt & (hold_ff != 3'h0);
  wire logic [2:0] nxt_hold  = ~link.odt ? 3'h0 : (hold_a > hold_w) ? hold_a : hold_w;

  always_ff @(posedge link.ck) begin
    if (srst) begin
      odt_prev_ff <= 1'b0;
      hold_ff     <= 3'h0;
      hold_err_ff <= 1'b0;
    end else begin
      odt_prev_ff <= link.odt;
      hold_ff     <= nxt_hold;
      hold_err_ff <= hold_err_ff | hold_miss;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rtt_state = rtt_ff;
  assign nom_code  = nom_code_ff;
  assign wr_code   = wr_code_ff;
  assign sync_mode = sync_ff;
  assign odt_int   = odt_int_ff;
  assign cfg_err   = cfg_err_ff;
  assign hold_err  = hold_err_ff;

endmodule

// >>> tb/sto_props.sv
`timescale 1ns/10ps
module sto_props (
  // link
  input wire logic              ck,
  input wire logic              srst,
  input wire logic              cke,
  input wire logic              odt,
  input wire logic              wr_cmd,
  input wire logic              wr_bc4,
  input wire logic              rd_cmd,
  input wire logic [1:0]        mr_al,
  input wire logic [3:0]        mr_cwl,
  input wire logic [3:0]        mr_cl,
  input wire logic [2:0]        mr_rtt_nom,
  input wire logic [1:0]        mr_rtt_wr,
  input wire logic              mr_dll_pd,
  // device state
  input wire sto_pkg::sto_rtt_t rtt_state,
  input wire logic              sync_mode,
  input wire logic              odt_int,
  input wire logic              hold_err
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic [31:0] hist_ff;
  logic [5:0]  st_ff;
  logic [17:0] mode_ff;
  wire  [17:0] mode_now = {mr_al, mr_cwl, mr_cl, mr_rtt_nom, mr_rtt_wr, mr_dll_pd, cke, sync_mode};
  wire  [4:0]  al_c = (mr_al == 2'h1) ? {1'b0, mr_cl} - 5'h01 : (mr_al == 2'h2) ? {1'b0, mr_cl} - 5'h02 : 5'h00;
  wire  [4:0]  lat = {1'b0, mr_cwl} + al_c - 5'h02;
  wire         settled = st_ff[5];
  wire         nom_on = (mr_rtt_nom != 3'h0) && (mr_rtt_nom < 3'h6);
  wire         dyn_on = (mr_rtt_wr == 2'h1) || (mr_rtt_wr == 2'h2);
  // fixed write window checks need a latency of 3
  wire         wl3 = settled && sync_mode && nom_on && dyn_on && (lat == 5'h03);
  always_ff @(posedge ck) begin
    hist_ff <= {hist_ff[30:0], odt};
    mode_ff <= mode_now;
    st_ff   <= (srst || mode_now != mode_ff) ? 6'h00 : (st_ff[5] ? st_ff : st_ff + 6'h01);
  end
  default clocking @(posedge ck); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_to_wr;
    ##4 (rtt_state == sto_pkg::STO_RTT_WR);
  endsequence
  property p_odt_lag;     settled |-> odt_int == hist_ff[al_c]; endproperty
  property p_rtt_follow;
    settled && sync_mode && nom_on |-> (rtt_state != sto_pkg::STO_RTT_OFF) == hist_ff[lat];
  endproperty
  property p_odth4;       $rose(odt) |-> odt[*4]; endproperty
  property p_odth4_wr;    wr_cmd && odt && wr_bc4 |-> odt[*4]; endproperty
  property p_odth8;       wr_cmd && odt && !wr_bc4 |-> odt[*6]; endproperty
  property p_rd_guard;    rd_cmd && mr_cl == 4'h6 && mr_cwl == 4'h5 |-> (!odt)[*8]; endproperty
  property p_dyn_bl8;
    wl3 && wr_cmd && odt && !wr_bc4 |-> s_to_wr ##1 (rtt_state == sto_pkg::STO_RTT_WR)[*5]
      ##1 (rtt_state != sto_pkg::STO_RTT_WR);
  endproperty
  property p_dyn_bc4;
    wl3 && wr_cmd && odt && wr_bc4 |-> s_to_wr ##1 (rtt_state == sto_pkg::STO_RTT_WR)[*3]
      ##1 (rtt_state != sto_pkg::STO_RTT_WR);
  endproperty
  property p_dyn_off;     settled && !dyn_on |-> rtt_state != sto_pkg::STO_RTT_WR; endproperty
  property p_no_hold_err; !hold_err; endproperty
  property p_sync_off;    settled && !nom_on && !dyn_on |-> !sync_mode; endproperty
  a_odt_lag:     assert property (p_odt_lag) else $error("odt_int lag wrong");
  a_rtt_follow:  assert property (p_rtt_follow) else $error("termination not following odt latency");
  a_odth4:       assert property (p_odth4) else $error("odt high under four cycles");
  a_odth4_wr:    assert property (p_odth4_wr) else $error("odt dropped early after short write");
  a_odth8:       assert property (p_odth8) else $error("odt dropped early after long write");
  a_rd_guard:    assert property (p_rd_guard) else $error("odt high during read window");
  a_dyn_bl8:     assert property (p_dyn_bl8) else $error("bad BL8 write window");
  a_dyn_bc4:     assert property (p_dyn_bc4) else $error("bad BC4 write window");
  a_dyn_off:     assert property (p_dyn_off) else $error("write termination without dynamic mode");
  a_no_hold_err: assert property (p_no_hold_err) else $error("hold error flagged");
  a_sync_off:    assert property (p_sync_off) else $error("sync mode with termination disabled");
endmodule

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic              clk, srst, dev_srst, dll_locked, banks_open;
  logic              awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0]        awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, wr_code;
  logic [2:0]        nom_code;
  logic              sync_mode, odt_int, cfg_err, hold_err;
  sto_pkg::sto_rtt_t rtt_state;
  int                mismatches = 0;
  int                samples_checked = 0;
  sto_link_if lk ();
  sto_mc_odt #(.CK_HALF(2)) sto_mc_odt_i (.clk(clk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(lk.ctrl));
  sto_dram_odt #(.HIST_W(32)) sto_dram_odt_i (.link(lk.dram), .srst(dev_srst), .dll_locked(dll_locked),
    .banks_open(banks_open), .rtt_state(rtt_state), .nom_code(nom_code), .wr_code(wr_code),
    .sync_mode(sync_mode), .odt_int(odt_int), .cfg_err(cfg_err), .hold_err(hold_err));
  sto_props sto_props_i (.ck(lk.ck), .srst(dev_srst), .cke(lk.cke), .odt(lk.odt), .wr_cmd(lk.wr_cmd),
    .wr_bc4(lk.wr_bc4), .rd_cmd(lk.rd_cmd), .mr_al(lk.mr_al), .mr_cwl(lk.mr_cwl), .mr_cl(lk.mr_cl),
    .mr_rtt_nom(lk.mr_rtt_nom), .mr_rtt_wr(lk.mr_rtt_wr), .mr_dll_pd(lk.mr_dll_pd), .rtt_state(rtt_state),
    .sync_mode(sync_mode), .odt_int(odt_int), .hold_err(hold_err));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask
  task automatic chk_rtt(input sto_pkg::sto_rtt_t got, input sto_pkg::sto_rtt_t exp);
    chk_word({30'h0, got}, {30'h0, exp});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge lk.ck);
    @(posedge clk);
  endtask
  task automatic wr_ctrl(input logic o, k, input logic [1:0] al, input logic [2:0] nom,
                         input logic [1:0] wr, input logic pd);
    axi_wr(sto_pkg::REG_CTRL, {14'h0, pd, wr, nom, 4'h6, 4'h5, al, k, o});
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = sto_pkg::RESP_OK);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk_word({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = sto_pkg::RESP_OK);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk_word(rdata, ed);
    chk_word({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic t_regs();
    axi_rd(sto_pkg::REG_CTRL, sto_pkg::CTRL_RST);
    axi_rd(8'h0C, 32'h0, sto_pkg::RESP_ERR);
    axi_wr(8'h0C, 32'hFFFF_FFFF, sto_pkg::RESP_ERR);
    axi_rd(sto_pkg::REG_CMD, 32'h0);
  endtask
  task automatic t_nominal();
    wr_ctrl(1, 1, 2'h0, 3'h1, 2'h0, 0);
    step(40);
    chk_rtt(rtt_state, sto_pkg::STO_RTT_NOM);
    chk_word({29'h0, nom_code}, 32'h1);
    axi_rd(sto_pkg::REG_STAT, 32'h1);
    wr_ctrl(1, 1, 2'h1, 3'h1, 2'h0, 0);
    step(40);
    chk_rtt(rtt_state, sto_pkg::STO_RTT_NOM);
    wr_ctrl(0, 1, 2'h1, 3'h1, 2'h0, 0);
    step(40);
    chk_rtt(rtt_state, sto_pkg::STO_RTT_OFF);
  endtask
  task automatic t_dyn();
    int n;
    wr_ctrl(0, 1, 2'h0, 3'h1, 2'h1, 0);
    step(40);
    chk_word({30'h0, wr_code}, 32'h1);
    for (int b = 0; b < 2; b++) begin
      axi_wr(sto_pkg::REG_CMD, {29'h0, b[0], 2'b01});
      n = 0;
      while (rtt_state !== sto_pkg::STO_RTT_WR && n < 200) begin
        step(1);
        n++;
      end
      chk_rtt(rtt_state, sto_pkg::STO_RTT_WR);
      n = 0;
      while (rtt_state === sto_pkg::STO_RTT_WR && n < 20) begin
        step(1);
        n++;
      end
      chk_word(32'(n), b ? 32'h4 : 32'h6);
      step(40);
    end
    wr_ctrl(0, 1, 2'h0, 3'h1, 2'h0, 0);
    step(40);
    axi_wr(sto_pkg::REG_CMD, 32'h1);
    step(20);
    chk_rtt(rtt_state, sto_pkg::STO_RTT_OFF);
  endtask
  task automatic t_read();
    wr_ctrl(1, 1, 2'h0, 3'h1, 2'h0, 0);
    step(40);
    axi_wr(sto_pkg::REG_CMD, 32'h2);
    step(60);
    axi_rd(sto_pkg::REG_STAT, 32'h1);
    chk_rtt(rtt_state, sto_pkg::STO_RTT_NOM);
  endtask
  task automatic t_modes();
    // row: dll, banks, cke, dll_pd, nominal code, expected sync mode
    logic [7:0] rows [6] = '{8'h82, 8'h93, 8'hC3, 8'h22, 8'hA0, 8'hAC};
    foreach (rows[i]) begin
      @(posedge clk);
      dll_locked <= rows[i][7];
      banks_open <= rows[i][6];
      wr_ctrl(0, rows[i][5], 2'h0, rows[i][3:1], 2'h0, rows[i][4]);
      step(12);
      chk_word({31'h0, sync_mode}, {31'h0, rows[i][0]});
      chk_word({31'h0, cfg_err}, {31'h0, rows[i][3:1] >= sto_pkg::NOM_RSV_MIN});
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    dev_srst = 1'b1;
    dll_locked = 1'b1;
    banks_open = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (16) @(posedge clk);
    dev_srst <= 1'b0;
    step(4);
    t_regs();
    t_nominal();
    t_dyn();
    t_read();
    t_modes();
    report_and_stop();
  end
  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end
endmodule
